// ### bcs_breaker_model.sv
// Breaker model: auxiliary contacts moved by the coil outputs
// Assumes level coil outputs; travel time counted in clock cycles
`timescale 1ns/1ns
`default_nettype none
module bcs_breaker_model #(
    parameter int TRAVEL = 40
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic open_coil_i,
    input  wire logic close_coil_i,
    input  wire logic flip_i,
    output logic      open_pos_o,
    output logic      closed_pos_o
);
    logic       closed_q;
    logic [7:0] travel_q;
    // Two contacts, both off while moving
    assign open_pos_o   = (travel_q == 8'h00) && !closed_q;
    assign closed_pos_o = (travel_q == 8'h00) && closed_q;
    // Flip moves it without any coil, as an uncommanded operation
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            closed_q <= 1'b1;
            travel_q <= 8'h00;
        end else if (travel_q != 8'h00) begin
            travel_q <= travel_q - 8'h01;
        end else if ((open_coil_i && closed_q) || (close_coil_i && !closed_q) || flip_i) begin
            closed_q <= !closed_q;
            travel_q <= TRAVEL[7:0];
        end
    end
endmodule
`default_nettype wire

// ### bcs_breaker_supervisor.sv
// Breaker command supervisor: APB registers, command checks, pulse and supervision timers
// Assumes position and permit inputs come from pins; APB on clk_i
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "bcs_regs.svh"

module bcs_breaker_supervisor (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [11:0]  paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    input  wire logic         open_position_in_i,
    input  wire logic         closed_position_in_i,
    input  wire logic         open_permit_i,
    input  wire logic         close_permit_i,
    input  wire logic         operation_block_i,
    input  wire logic         sync_permit_i,
    input  wire logic         panel_permit_i,
    input  wire logic         remote_permit_i,
    input  wire logic         external_switch_flag_i,
    output logic              open_cmd_o,
    output logic              close_cmd_o,
    output logic              sync_switch_trigger_o,
    output logic              operation_pulse_o,
    output logic              unintended_operation_o,
    output logic              breaker_open_o,
    output logic              breaker_closed_o,
    output logic              breaker_intermediate_o,
    output bcs_pkg::bcs_pos_e position_o
);
    import bcs_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_SELECTED, S_SYNC_WAIT, S_SYNC_SW, S_PULSE, S_SUPERVISE
    } bcs_state_e;

    localparam int TICK_CYC = `BCS_TICK_CYCLES;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        hit = (a == b);
    endfunction

    // Pin synchronisers: first stage read only by second
    logic [8:0] pin_meta_q;
    logic [8:0] pin_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_meta_q <= 9'h000;
            pin_q      <= 9'h000;
        end else begin
            pin_meta_q <= {external_switch_flag_i, remote_permit_i, panel_permit_i,
                           sync_permit_i, operation_block_i, close_permit_i,
                           open_permit_i, closed_position_in_i, open_position_in_i};
            pin_q      <= pin_meta_q;
        end
    end
    logic pos_open, pos_closed, en_open, en_close, blk, syn_ok, pnl_ok, rem_ok, ext_sw;
    assign {ext_sw, rem_ok, pnl_ok, syn_ok, blk, en_close, en_open, pos_closed, pos_open} = pin_q;

    // Millisecond tick
    logic [15:0] div_q;
    logic        tick;
    assign tick = (div_q == 16'(TICK_CYC - 1));
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= tick ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // Configuration registers
    logic        local_en_q, remote_en_q, forced_q;
    bcs_scheme_e scheme_q;
    bcs_ms_t     optime_q, pulse_q, interm_q, synchk_q, synsw_q, selto_q;
    logic        wr, rd;
    assign wr = psel_i && penable_i && pwrite_i;
    assign rd = psel_i && penable_i && !pwrite_i;
    assign pready_o = 1'b1;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            local_en_q  <= 1'b1;
            remote_en_q <= 1'b1;
            forced_q    <= 1'b1;
            scheme_q    <= BCS_DIRECT_NORMAL;
            optime_q    <= `BCS_OPTIME_RESET;
            pulse_q     <= `BCS_PULSE_RESET;
            interm_q    <= `BCS_INTERM_RESET;
            synchk_q    <= `BCS_SYNCHK_RESET;
            synsw_q     <= `BCS_SYNSW_RESET;
            selto_q     <= `BCS_SELTO_RESET;
        end else if (wr) begin
            if (hit(paddr_i, `BCS_ADDR_CTRL)) begin
                local_en_q  <= pwdata_i[`BCS_CTRL_LOCAL_EN];
                remote_en_q <= pwdata_i[`BCS_CTRL_REMOTE_EN];
                forced_q    <= pwdata_i[`BCS_CTRL_FORCED];
                scheme_q    <= bcs_scheme_e'(pwdata_i[`BCS_CTRL_SCHEME_LO +: 2]);
            end else if (hit(paddr_i, `BCS_ADDR_OPTIME)) begin
                optime_q <= pwdata_i[15:0];
            end else if (hit(paddr_i, `BCS_ADDR_PULSE)) begin
                pulse_q <= pwdata_i[15:0];
            end else if (hit(paddr_i, `BCS_ADDR_INTERM)) begin
                interm_q <= pwdata_i[15:0];
            end else if (hit(paddr_i, `BCS_ADDR_SYNCHK)) begin
                synchk_q <= pwdata_i[15:0];
            end else if (hit(paddr_i, `BCS_ADDR_SYNSW)) begin
                synsw_q <= pwdata_i[15:0];
            end else if (hit(paddr_i, `BCS_ADDR_SELTO)) begin
                selto_q <= pwdata_i[15:0];
            end
        end
    end

    logic mapped;
    assign mapped = hit(paddr_i, `BCS_ADDR_CTRL) || hit(paddr_i, `BCS_ADDR_OPTIME)
                 || hit(paddr_i, `BCS_ADDR_PULSE) || hit(paddr_i, `BCS_ADDR_INTERM)
                 || hit(paddr_i, `BCS_ADDR_SYNCHK) || hit(paddr_i, `BCS_ADDR_SYNSW)
                 || hit(paddr_i, `BCS_ADDR_SELTO) || hit(paddr_i, `BCS_ADDR_CMD)
                 || hit(paddr_i, `BCS_ADDR_STATUS);
    assign pslverr_o = psel_i && penable_i && !mapped;

    // Command decode
    logic cmd_wr, cmd_close, cmd_open, cmd_remote, cmd_skip, cmd_select, cmd_cancel;
    assign cmd_wr     = wr && hit(paddr_i, `BCS_ADDR_CMD);
    assign cmd_close  = pwdata_i[`BCS_CMD_CLOSE];
    assign cmd_open   = pwdata_i[`BCS_CMD_OPEN];
    assign cmd_remote = pwdata_i[`BCS_CMD_REMOTE];
    assign cmd_skip   = pwdata_i[`BCS_CMD_SKIP_CHECK];
    assign cmd_select = pwdata_i[`BCS_CMD_SELECT];
    assign cmd_cancel = pwdata_i[`BCS_CMD_CANCEL];

    logic src_ok, do_check, perm_ok, cmd_valid;
    assign src_ok = cmd_remote ? (remote_en_q && rem_ok) : (local_en_q && pnl_ok);
    assign do_check = forced_q || !cmd_skip;
    assign perm_ok = !do_check || (cmd_open ? en_open : en_close);
    assign cmd_valid = cmd_wr && (cmd_open ^ cmd_close) && src_ok && !blk;

    // Position decode
    bcs_pos_e pos_raw;
    always_comb begin
        if (pos_open && !pos_closed) begin
            pos_raw = BCS_POS_OPEN;
        end else if (pos_closed && !pos_open) begin
            pos_raw = BCS_POS_CLOSED;
        end else if (pos_open) begin
            pos_raw = BCS_POS_FAULT;
        end else begin
            pos_raw = BCS_POS_INTERMEDIATE;
        end
    end

    bcs_ms_t  trans_ms_q;
    bcs_pos_e pos_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trans_ms_q <= 16'h0000;
            pos_q      <= BCS_POS_INTERMEDIATE;
        end else if (pos_raw == BCS_POS_OPEN || pos_raw == BCS_POS_CLOSED) begin
            trans_ms_q <= 16'h0000;
            pos_q      <= pos_raw;
        end else if (tick) begin
            if (trans_ms_q >= interm_q) begin
                pos_q <= pos_raw;
            end else begin
                trans_ms_q <= trans_ms_q + 16'h0001;
            end
        end
    end
    assign position_o             = pos_q;
    assign breaker_open_o         = (pos_q == BCS_POS_OPEN);
    assign breaker_closed_o       = (pos_q == BCS_POS_CLOSED);
    assign breaker_intermediate_o = (pos_q == BCS_POS_INTERMEDIATE) || (pos_q == BCS_POS_FAULT);

    // Command state machine
    bcs_state_e st_q;
    bcs_ms_t    tmr_q, sup_q;
    logic       is_close_q, is_remote_q, chk_q, pos_err_q, rejected_q, abandoned_q;
    logic       enhanced, reached;
    assign enhanced = (scheme_q == BCS_DIRECT_ENHANCED) || (scheme_q == BCS_SBO_ENHANCED);
    assign reached  = is_close_q ? (pos_raw == BCS_POS_CLOSED) : (pos_raw == BCS_POS_OPEN);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q        <= S_IDLE;
            tmr_q       <= 16'h0000;
            sup_q       <= 16'h0000;
            is_close_q  <= 1'b0;
            is_remote_q <= 1'b0;
            chk_q       <= 1'b1;
            pos_err_q   <= 1'b0;
            rejected_q  <= 1'b0;
            abandoned_q <= 1'b0;
        end else begin
            if (cmd_wr && st_q != S_IDLE && !(st_q == S_SELECTED)) begin
                rejected_q <= 1'b1;
            end
            case (st_q)
            S_IDLE: begin
                if (cmd_valid) begin
                    is_close_q  <= cmd_close;
                    is_remote_q <= cmd_remote;
                    chk_q       <= do_check;
                    tmr_q       <= 16'h0000;
                    pos_err_q   <= 1'b0;
                    rejected_q  <= 1'b0;
                    abandoned_q <= 1'b0;
                    if (scheme_q == BCS_SBO_ENHANCED && cmd_select) begin
                        st_q <= S_SELECTED;
                    end else if (scheme_q == BCS_SBO_ENHANCED || !perm_ok) begin
                        rejected_q <= 1'b1;
                    end else begin
                        st_q <= cmd_close && do_check ? S_SYNC_WAIT : S_PULSE;
                    end
                end else if (cmd_wr) begin
                    rejected_q <= 1'b1;
                end
            end
            S_SELECTED: begin
                if (cmd_wr) begin
                    tmr_q <= 16'h0000;
                    if (cmd_cancel || !cmd_valid || cmd_select || !perm_ok
                        || cmd_close != is_close_q) begin
                        rejected_q <= !cmd_cancel;
                        st_q       <= S_IDLE;
                    end else begin
                        st_q <= is_close_q && do_check ? S_SYNC_WAIT : S_PULSE;
                    end
                end else if (tick) begin
                    if (tmr_q >= selto_q - 16'h0001) begin
                        abandoned_q <= 1'b1;
                        st_q        <= S_IDLE;
                    end
                    tmr_q <= tmr_q + 16'h0001;
                end
            end
            S_SYNC_WAIT: begin
                if (syn_ok) begin
                    tmr_q <= 16'h0000;
                    st_q  <= S_PULSE;
                end else if (tick) begin
                    tmr_q <= tmr_q + 16'h0001;
                    if (tmr_q >= synchk_q - 16'h0001) begin
                        tmr_q <= 16'h0000;
                        if (synsw_q == 16'h0000) begin
                            abandoned_q <= 1'b1;
                            st_q        <= S_IDLE;
                        end else begin
                            st_q <= S_SYNC_SW;
                        end
                    end
                end
            end
            S_SYNC_SW: begin
                if (syn_ok) begin
                    tmr_q <= 16'h0000;
                    st_q  <= S_PULSE;
                end else if (tick) begin
                    tmr_q <= tmr_q + 16'h0001;
                    if (tmr_q >= synsw_q - 16'h0001) begin
                        abandoned_q <= 1'b1;
                        st_q        <= S_IDLE;
                    end
                end
            end
            S_PULSE: begin
                if (tick) begin
                    tmr_q <= tmr_q + 16'h0001;
                    sup_q <= sup_q + 16'h0001;
                end
                if (tick && tmr_q >= `BCS_PULSE_MIN_MS - 16'h0001
                         && (reached || tmr_q >= pulse_q - 16'h0001)) begin
                    st_q <= S_SUPERVISE;
                end
            end
            S_SUPERVISE: begin
                if (tick) begin
                    sup_q <= sup_q + 16'h0001;
                end
                if (reached || !enhanced) begin
                    sup_q <= 16'h0000;
                    st_q  <= S_IDLE;
                end else if (tick && sup_q >= optime_q - 16'h0001) begin
                    pos_err_q <= 1'b1;
                    sup_q     <= 16'h0000;
                    st_q      <= S_IDLE;
                end
            end
            default: st_q <= S_IDLE;
            endcase
            if (st_q == S_IDLE) begin
                sup_q <= 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            open_cmd_o            <= 1'b0;
            close_cmd_o           <= 1'b0;
            sync_switch_trigger_o <= 1'b0;
        end else begin
            open_cmd_o            <= (st_q == S_PULSE) && !is_close_q && !blk;
            close_cmd_o           <= (st_q == S_PULSE) && is_close_q && !blk;
            sync_switch_trigger_o <= (st_q == S_SYNC_SW);
        end
    end

    bcs_pos_e last_pos_q;
    bcs_ms_t  oper_ms_q;
    logic     oper_act_q, cmd_seen_q;
    logic     pos_change;
    assign pos_change = (pos_q != last_pos_q)
                     && (pos_q == BCS_POS_OPEN || pos_q == BCS_POS_CLOSED);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_pos_q             <= BCS_POS_INTERMEDIATE;
            oper_ms_q              <= 16'h0000;
            oper_act_q             <= 1'b0;
            cmd_seen_q             <= 1'b0;
            unintended_operation_o <= 1'b0;
        end else begin
            if (pos_q == BCS_POS_OPEN || pos_q == BCS_POS_CLOSED) begin
                last_pos_q <= pos_q;
            end
            if (st_q == S_PULSE && is_remote_q) begin
                cmd_seen_q <= 1'b1;
            end else if (pos_change) begin
                cmd_seen_q <= 1'b0;
            end
            if (pos_change && last_pos_q != BCS_POS_INTERMEDIATE) begin
                oper_act_q             <= 1'b1;
                oper_ms_q              <= 16'h0000;
                unintended_operation_o <= !cmd_seen_q && !ext_sw;
            end else if (oper_act_q && tick) begin
                oper_ms_q <= oper_ms_q + 16'h0001;
                if (oper_ms_q >= `BCS_OPER_PULSE_MS - 16'h0001) begin
                    oper_act_q <= 1'b0;
                end
            end
        end
    end
    assign operation_pulse_o = oper_act_q;

    // Read mux
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            if (hit(paddr_i, `BCS_ADDR_CTRL)) begin
                prdata_o <= {26'h0, scheme_q, 1'b0, forced_q, remote_en_q, local_en_q};
            end else if (hit(paddr_i, `BCS_ADDR_OPTIME)) begin
                prdata_o <= {16'h0, optime_q};
            end else if (hit(paddr_i, `BCS_ADDR_PULSE)) begin
                prdata_o <= {16'h0, pulse_q};
            end else if (hit(paddr_i, `BCS_ADDR_INTERM)) begin
                prdata_o <= {16'h0, interm_q};
            end else if (hit(paddr_i, `BCS_ADDR_SYNCHK)) begin
                prdata_o <= {16'h0, synchk_q};
            end else if (hit(paddr_i, `BCS_ADDR_SYNSW)) begin
                prdata_o <= {16'h0, synsw_q};
            end else if (hit(paddr_i, `BCS_ADDR_SELTO)) begin
                prdata_o <= {16'h0, selto_q};
            end else if (hit(paddr_i, `BCS_ADDR_STATUS)) begin
                prdata_o <= {22'h0, st_q, abandoned_q, rejected_q, pos_err_q,
                             unintended_operation_o, chk_q, pos_q};
            end else begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end
    logic unused_rd;
    assign unused_rd = rd;
endmodule
`default_nettype wire

// ### bcs_pkg.sv
// Types of the breaker command supervisor
// Used by the supervisor, its property checker and the bench
package bcs_pkg;
    typedef enum logic [1:0] {
        BCS_DIRECT_NORMAL,
        BCS_DIRECT_ENHANCED,
        BCS_SBO_ENHANCED,
        BCS_SCHEME_RSVD
    } bcs_scheme_e;

    typedef enum logic [1:0] {
        BCS_POS_INTERMEDIATE,
        BCS_POS_OPEN,
        BCS_POS_CLOSED,
        BCS_POS_FAULT
    } bcs_pos_e;

    typedef logic [15:0] bcs_ms_t;
endpackage

// ### bcs_props.sv
// Checker of the coil, pulse and position outputs of the supervisor
// Assumes a 20 MHz clock, so 1 ms is 20000 cycles
`timescale 1ns/1ns
`default_nettype none
module bcs_props (
    input wire logic              clk_i,
    input wire logic              arst_n_i,
    input wire logic              open_position_in_i,
    input wire logic              closed_position_in_i,
    input wire logic              operation_block_i,
    input wire logic              open_cmd_o,
    input wire logic              close_cmd_o,
    input wire logic              operation_pulse_o,
    input wire logic              breaker_open_o,
    input wire logic              breaker_closed_o,
    input wire logic              breaker_intermediate_o,
    input wire bcs_pkg::bcs_pos_e position_o
);
    import bcs_pkg::*;
    localparam int Ms = 20000;
    logic [31:0] coil_q;
    logic [31:0] oper_q;
    logic [31:0] inv_q;
    // Cycle counts, compared with 1 ms slack for tick phase
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            coil_q <= '0;
            oper_q <= '0;
            inv_q  <= '0;
        end else begin
            coil_q <= (open_cmd_o || close_cmd_o) ? coil_q + 32'h1 : '0;
            oper_q <= operation_pulse_o ? oper_q + 32'h1 : '0;
            inv_q  <= (open_position_in_i ^ closed_position_in_i) ? '0 : inv_q + 32'h1;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    excl_cmd_a: assert property (!(open_cmd_o && close_cmd_o))
        else $error("both coils driven");
    blk_hold_a: assert property (
        operation_block_i [*6] |=> !$rose(open_cmd_o || close_cmd_o))
        else $error("coil pulse began while blocked");
    pulse_min_a: assert property (
        $fell(open_cmd_o || close_cmd_o) |-> coil_q >= 32'(99 * Ms))
        else $error("coil pulse too short");
    pulse_max_a: assert property (coil_q <= 32'(1001 * Ms))
        else $error("coil pulse too long");
    oper_max_a: assert property (oper_q <= 32'(151 * Ms))
        else $error("operation pulse too long");
    oper_min_a: assert property ($fell(operation_pulse_o) |-> oper_q >= 32'(149 * Ms))
        else $error("operation pulse too short");
    open_follow_a: assert property (
        (open_position_in_i && !closed_position_in_i) [*4] |-> position_o == BCS_POS_OPEN)
        else $error("open contact not reported");
    pos_decode_a: assert property (
        breaker_open_o == (position_o == BCS_POS_OPEN)
        && breaker_closed_o == (position_o == BCS_POS_CLOSED))
        else $error("position flags disagree");
    interm_filter_a: assert property (
        $rose(breaker_intermediate_o) |-> inv_q >= 32'(19 * Ms))
        else $error("intermediate reported early");
    cover property ($rose(open_cmd_o));
    cover property ($rose(operation_pulse_o));
    cover property ($rose(breaker_open_o));
endmodule

bind bcs_breaker_supervisor bcs_props u_props (
    .clk_i, .arst_n_i, .open_position_in_i, .closed_position_in_i, .operation_block_i,
    .open_cmd_o, .close_cmd_o, .operation_pulse_o, .breaker_open_o, .breaker_closed_o,
    .breaker_intermediate_o, .position_o
);
`default_nettype wire

// ### bcs_regs.svh
// Register map, field layout, reset values and timing constants of the breaker command supervisor
// Assumes a 20 MHz clock; all supervision times count in 1 ms ticks
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH

`define BCS_ADDR_CTRL       12'h000
`define BCS_ADDR_OPTIME     12'h004
`define BCS_ADDR_PULSE      12'h008
`define BCS_ADDR_INTERM     12'h00c
`define BCS_ADDR_SYNCHK     12'h010
`define BCS_ADDR_SYNSW      12'h014
`define BCS_ADDR_SELTO      12'h018
`define BCS_ADDR_CMD        12'h01c
`define BCS_ADDR_STATUS     12'h020

// Control register fields
`define BCS_CTRL_LOCAL_EN   0
`define BCS_CTRL_REMOTE_EN  1
`define BCS_CTRL_FORCED     2
`define BCS_CTRL_SCHEME_LO  4
`define BCS_CTRL_RESET      32'h0000_0007

// Command register fields (write only)
`define BCS_CMD_CLOSE       0
`define BCS_CMD_OPEN        1
`define BCS_CMD_REMOTE      2
`define BCS_CMD_SKIP_CHECK  3
`define BCS_CMD_SELECT      4
`define BCS_CMD_CANCEL      5

`define BCS_OPTIME_RESET    16'd200
`define BCS_PULSE_RESET     16'd300
`define BCS_INTERM_RESET    16'd100
`define BCS_SYNCHK_RESET    16'd1000
`define BCS_SYNSW_RESET     16'd0
`define BCS_SELTO_RESET     16'd5000
`define BCS_PULSE_MIN_MS    16'd100
`define BCS_OPER_PULSE_MS   16'd150

`define BCS_CLK_HZ          20000000
`define BCS_TICK_MS         1
`define BCS_TICK_CYCLES     ((`BCS_CLK_HZ / 1000) * `BCS_TICK_MS)

`endif

// ### tb_top.sv
// Self-checking bench for the breaker command supervisor
// Assumes the design and the breaker model are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "bcs_regs.svh"
module tb_top;
    import bcs_pkg::*;
    localparam int Travel = 40;
    localparam int Ms = `BCS_TICK_CYCLES;
    logic        clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        open_position_in_i, closed_position_in_i, open_permit_i, close_permit_i;
    logic        operation_block_i, sync_permit_i, panel_permit_i, remote_permit_i;
    logic        external_switch_flag_i, open_cmd_o, close_cmd_o, sync_switch_trigger_o;
    logic        operation_pulse_o, unintended_operation_o, breaker_open_o, breaker_closed_o;
    logic        breaker_intermediate_o, flip, slverr;
    bcs_pos_e    position_o;
    int          err_count, checks_done, cycles;

    bcs_breaker_supervisor u_dut (
        .clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .open_position_in_i, .closed_position_in_i, .open_permit_i,
        .close_permit_i, .operation_block_i, .sync_permit_i, .panel_permit_i,
        .remote_permit_i, .external_switch_flag_i, .open_cmd_o, .close_cmd_o,
        .sync_switch_trigger_o, .operation_pulse_o, .unintended_operation_o,
        .breaker_open_o, .breaker_closed_o, .breaker_intermediate_o, .position_o
    );
    bcs_breaker_model #(.TRAVEL(Travel)) u_brk (
        .clk_i, .arst_n_i, .open_coil_i(open_cmd_o), .close_coil_i(close_cmd_o),
        .flip_i(flip), .open_pos_o(open_position_in_i), .closed_pos_o(closed_position_in_i)
    );

    task automatic print_verdict();
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Idle edge first: psel never set and cleared at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd = prdata_o;
        slverr = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic t_regs();
        logic [31:0] exp [8] = '{32'h7, 32'hc8, 32'h12c, 32'h64, 32'h3e8, 32'h0, 32'h1388, 32'h0};
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check(rd, exp[i]);
        end
        apb(1'b0, 12'h040, 32'h0);
        check({31'h0, slverr}, 32'h1);
        apb(1'b1, `BCS_ADDR_PULSE, 32'h32);
        apb(1'b0, `BCS_ADDR_PULSE, 32'h0);
        check(rd, 32'h32);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0);
        check({30'h0, rd[1:0]}, 32'(BCS_POS_CLOSED));
    endtask
    // Panel disabled, panel permit, open permit, block, forced check
    task automatic t_refused();
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `BCS_ADDR_CTRL, (i == 0) ? 32'h6 : 32'h7);
            panel_permit_i    <= (i != 1);
            open_permit_i     <= !(i == 2 || i == 4);
            operation_block_i <= (i == 3);
            repeat (4) @(posedge clk_i);
            apb(1'b1, `BCS_ADDR_CMD, (i == 4) ? 32'ha : 32'h2);
            repeat (10) @(posedge clk_i);
            check(32'(open_cmd_o), 32'h0);
        end
        open_permit_i <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic t_remote_open();
        int n;
        apb(1'b1, `BCS_ADDR_CTRL, 32'h27);
        apb(1'b1, `BCS_ADDR_CMD, 32'h6);
        apb(1'b1, `BCS_ADDR_CMD, 32'h16);
        check(32'(open_cmd_o), 32'h0);
        apb(1'b1, `BCS_ADDR_CMD, 32'h6);
        for (n = 0; n < 10 && open_cmd_o !== 1'b1; n++) @(posedge clk_i);
        check(32'(open_cmd_o), 32'h1);
        apb(1'b1, `BCS_ADDR_CMD, 32'h5);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0);
        check(32'(rd[5]), 32'h1);
        repeat (Travel + 8) @(posedge clk_i);
        check(32'(close_cmd_o), 32'h0);
        check(32'(position_o), 32'(BCS_POS_OPEN));
        check(32'(operation_pulse_o), 32'h1);
        check(32'(unintended_operation_o), 32'h0);
        check(32'(open_cmd_o), 32'h1);
    endtask
    // Second reset, then moves without a command: first bare, then flagged external
    task automatic t_unintended();
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            external_switch_flag_i <= (i == 1);
            repeat (5) @(posedge clk_i);
            flip <= 1'b1;
            @(posedge clk_i);
            flip <= 1'b0;
            repeat (Travel + 8) @(posedge clk_i);
            check(32'(unintended_operation_o), 32'(i == 0));
        end
    endtask

    task automatic t_sync();
        int n;
        sync_permit_i <= 1'b0;
        apb(1'b1, `BCS_ADDR_SYNCHK, 32'h2);
        apb(1'b1, `BCS_ADDR_SYNSW, 32'h1);
        apb(1'b1, `BCS_ADDR_CMD, 32'h5);
        for (n = 0; n < 2 * Ms + 99 && sync_switch_trigger_o !== 1'b1; n++) @(posedge clk_i);
        check(32'(n > Ms), 32'h1);
        repeat (Ms - 9) @(posedge clk_i);
        check(32'(sync_switch_trigger_o), 32'h1);
        repeat (19) @(posedge clk_i);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0);
        check(32'({rd[6], sync_switch_trigger_o, close_cmd_o}), 32'h4);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        {psel_i, penable_i, pwrite_i, flip, operation_block_i, external_switch_flag_i} = '0;
        {open_permit_i, close_permit_i, sync_permit_i, panel_permit_i, remote_permit_i} = '1;
        paddr_i = '0;
        pwdata_i = '0;
        arst_n_i = 1'b0;
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_refused();
        t_remote_open();
        t_unintended();
        t_sync();
        print_verdict();
    end
endmodule
`default_nettype wire
